// ---- rtl/dch_homing.v ----
// Purpose : dog-type and count-type home position return sequencer
// Assumes : one clock CORE_CLK 25 MHz, synchronous active-low RESETN
// Notes   : pins pass two flip-flops; distances count FB_STEP pulses
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dch_defs.vh"

// Functional notes
// R1: host sets auto/manual select before asking for a home return.
// R2: host drives all eight point-table select bits to zero.
// R3: with two stations, host also sets position/speed source select.
// R4: method low digit 0 selects dog-type homing.
// R5: method low digit 1 selects count-type homing.
// R6: homing speed until dog found, creep speed afterwards.
// R7: dog mode decelerates at front end, home at first index past rear.
// R8: dog mode shifts home by shift distance from that index pulse.
// R9: point table one accel/decel constants drive all homing motion.
// R10: on completion current position loads the home position data.
// R11: count mode travels post-dog distance then takes next index.
// R12: dog source holds dog active at least 10 ms in count mode.
// R13: count mode shift distance starts at index after post-dog travel.
// R14: start direction follows the homing direction setting.
// R15: dog input is read through the dog polarity setting.
// R16: host changes point-table select early for fieldbus delay.
// R17: direction 0 moves to rising addresses, 1 to falling ones.
// R18: polarity 0 detects dog when off, 1 when on.
// R19: homing-complete output rises once home reached and position loaded.
// R20: index pulses count only in the seek phase of homing.
module dch_homing
(
   // clock and reset
   input  wire        CORE_CLK,
   input  wire        RESETN,
   // apb slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // host remote inputs
   input  wire        HOME_START,
   input  wire        AUTO_MANUAL_SELECT,
   input  wire [7:0]  POINT_TABLE_SEL,
   input  wire        POS_SPEED_SOURCE_SELECT,
   input  wire        TWO_STATIONS,
   // machine sensors
   input  wire        DOG_IN,
   input  wire        INDEX_PULSE,
   input  wire        FB_STEP,
   // motion command
   output reg  [31:0] CMD_SPEED,
   output reg         CMD_DIR_DOWN,
   output reg  [15:0] CMD_ACC_TIME,
   output reg  [15:0] CMD_DEC_TIME,
   output reg         CMD_DECEL,
   // status
   output reg         HOME_BUSY,
   output reg         HOME_COMPLETE,
   output reg         HOME_ERROR
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [2:0] ST_IDLE  = 3'h0;
localparam [2:0] ST_FAST  = 3'h1;
localparam [2:0] ST_REAR  = 3'h2;
localparam [2:0] ST_TRVL  = 3'h3;
localparam [2:0] ST_SEEK  = 3'h4;
localparam [2:0] ST_SHIFT = 3'h5;
localparam [2:0] ST_DONE  = 3'h6;
localparam [2:0] ST_ERR   = 3'h7;
localparam       NSYNC    = 15;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
wire [NSYNC-1:0] pin_raw;
wire [NSYNC-1:0] pin_s;
reg  [NSYNC-1:0] pin_m_q;
reg  [NSYNC-1:0] pin_s_q;
reg  [2:0]       edge_q;
genvar gi;

assign pin_raw = {HOME_START, AUTO_MANUAL_SELECT, POINT_TABLE_SEL,
                  POS_SPEED_SOURCE_SELECT, TWO_STATIONS, DOG_IN,
                  INDEX_PULSE, FB_STEP};

generate
   for (gi = 0; gi < NSYNC; gi = gi + 1)
   begin : g_sync
      always @(posedge CORE_CLK)
      begin
         if (!RESETN)
         begin
            pin_m_q[gi] <= 1'b0;
            pin_s_q[gi] <= 1'b0;
         end
         else
         begin
            pin_m_q[gi] <= pin_raw[gi];
            pin_s_q[gi] <= pin_m_q[gi];
         end
      end
   end
endgenerate
assign pin_s = pin_s_q;

wire       start_s   = pin_s[14];
wire       auto_man  = pin_s[13];
wire [7:0] pt_sel    = pin_s[12:5];
wire       src_sel   = pin_s[4];
wire       two_st    = pin_s[3];
wire       dog_s     = pin_s[2];
wire       index_s   = pin_s[1];
wire       step_s    = pin_s[0];

// edge detectors on the second stage only
always @(posedge CORE_CLK)
begin
   if (!RESETN)
      edge_q <= 3'h0;
   else
      edge_q <= {start_s, index_s, step_s};
end
wire start_rise = start_s & ~edge_q[2];
wire index_rise = index_s & ~edge_q[1];
wire step_rise  = step_s  & ~edge_q[0];

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [31:0] mode_q;
reg [31:0] hspeed_q;
reg [31:0] creep_q;
reg [31:0] shift_q;
reg [31:0] homepos_q;
reg [31:0] postdog_q;
reg [31:0] accdec_q;
reg        abort_q;
reg [31:0] curpos_q;
reg [2:0]  state_q;
reg [2:0]  state_d;
reg [31:0] remain_q;
reg [31:0] remain_d;
reg        dog_prev_q;

function [3:0] reg_index;
   input [7:0] addr;
   begin
      case (addr)
         `DCH_OFS_CTRL:    reg_index = 4'h0;
         `DCH_OFS_MODE:    reg_index = 4'h1;
         `DCH_OFS_HSPEED:  reg_index = 4'h2;
         `DCH_OFS_CREEP:   reg_index = 4'h3;
         `DCH_OFS_SHIFT:   reg_index = 4'h4;
         `DCH_OFS_HOMEPOS: reg_index = 4'h5;
         `DCH_OFS_POSTDOG: reg_index = 4'h6;
         `DCH_OFS_ACCDEC:  reg_index = 4'h7;
         `DCH_OFS_STATUS:  reg_index = 4'h8;
         `DCH_OFS_CURPOS:  reg_index = 4'h9;
         default:          reg_index = 4'hf;
      endcase
   end
endfunction

// answer one cycle into the access phase
wire       apb_setup = PSEL & ~PENABLE;
wire       apb_done  = PSEL & PENABLE & PREADY;
wire [3:0] rd_idx    = reg_index(PADDR);
wire       wr_now    = apb_done & PWRITE & ~PSLVERR;

always @(posedge CORE_CLK)
begin
   if (!RESETN)
   begin
      PREADY    <= 1'b0;
      PSLVERR   <= 1'b0;
      PRDATA    <= `DCH_RST_WORD;
   end
   else
   begin
      PREADY    <= apb_setup;
      PSLVERR   <= apb_setup & (rd_idx == 4'hf);
      if (apb_setup & ~PWRITE)
      begin
         case (rd_idx)
            4'h0:    PRDATA <= {31'h0, abort_q};
            4'h1:    PRDATA <= mode_q;
            4'h2:    PRDATA <= hspeed_q;
            4'h3:    PRDATA <= creep_q;
            4'h4:    PRDATA <= shift_q;
            4'h5:    PRDATA <= homepos_q;
            4'h6:    PRDATA <= postdog_q;
            4'h7:    PRDATA <= accdec_q;
            4'h8:    PRDATA <= {25'h0, dog_prev_q, HOME_ERROR,
                                HOME_COMPLETE, HOME_BUSY, state_q};
            4'h9:    PRDATA <= curpos_q;
            default: PRDATA <= `DCH_RST_WORD;
         endcase
      end
      else
         PRDATA <= `DCH_RST_WORD;
   end
end

always @(posedge CORE_CLK)
begin
   if (!RESETN)
   begin
      abort_q   <= 1'b0;
      mode_q    <= `DCH_RST_MODE;
      hspeed_q  <= `DCH_RST_SPEED;
      creep_q   <= `DCH_RST_SPEED;
      shift_q   <= `DCH_RST_WORD;
      homepos_q <= `DCH_RST_WORD;
      postdog_q <= `DCH_RST_WORD;
      accdec_q  <= `DCH_RST_ACCDEC;
   end
   else
   begin
      // abort is a one-shot; it self-clears the cycle after the write
      abort_q <= wr_now & (rd_idx == 4'h0) & PWDATA[`DCH_CTRL_ABORT];
      if (wr_now)
      begin
         case (rd_idx)
            4'h1:    mode_q    <= PWDATA;
            4'h2:    hspeed_q  <= PWDATA;
            4'h3:    creep_q   <= PWDATA;
            4'h4:    shift_q   <= PWDATA;
            4'h5:    homepos_q <= PWDATA;
            4'h6:    postdog_q <= PWDATA;
            4'h7:    accdec_q  <= PWDATA;
            default: mode_q    <= mode_q;
         endcase
      end
   end
end

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
wire [3:0] method   = mode_q[3:0];
wire       dir_down = mode_q[`DCH_MODE_DIR];                  // [R14] [R17]
wire       dog_act  = mode_q[`DCH_MODE_POL] ? dog_s : ~dog_s; // [R15] [R18]
wire       dog_front = dog_act & ~dog_prev_q;
wire       dog_rear  = ~dog_act & dog_prev_q;
// request is only honoured with the host's mode bits in place
wire       req_ok   = auto_man & (pt_sel == 8'h00) & (~two_st | src_sel);
wire       moving   = (state_q != ST_IDLE) & (state_q != ST_DONE) &
                      (state_q != ST_ERR);

always @*
begin
   state_d  = state_q;
   remain_d = remain_q;
   if (step_rise & (remain_q != 32'h0))
      remain_d = remain_q - 32'h1;
   case (state_q)
      ST_IDLE, ST_DONE, ST_ERR:
      begin
         if (start_rise)
         begin
            if (~req_ok)
               state_d = ST_ERR;
            else if ((method == `DCH_METHOD_DOG) |               // [R4]
                     (method == `DCH_METHOD_COUNT))              // [R5]
               state_d = ST_FAST;
            else
               state_d = ST_ERR;
         end
      end
      ST_FAST:
      begin
         if (dog_front)
         begin
            if (method == `DCH_METHOD_COUNT)
            begin
               state_d  = ST_TRVL;                               // [R11]
               remain_d = postdog_q;
            end
            else
               state_d = ST_REAR;                                // [R7]
         end
      end
      ST_REAR:
      begin
         if (dog_rear)
            state_d = ST_SEEK;                                   // [R7]
      end
      ST_TRVL:
      begin
         if (remain_d == 32'h0)
            state_d = ST_SEEK;                                   // [R11]
      end
      ST_SEEK:
      begin
         if (index_rise)                                         // [R20]
         begin
            remain_d = shift_q;                                  // [R8] [R13]
            state_d  = ST_SHIFT;
         end
      end
      ST_SHIFT:
      begin
         if (remain_d == 32'h0)
            state_d = ST_DONE;
      end
      default:
         state_d = ST_IDLE;
   endcase
   if (abort_q & moving)
      state_d = ST_ERR;
end

always @(posedge CORE_CLK)
begin
   if (!RESETN)
   begin
      state_q    <= ST_IDLE;
      remain_q   <= 32'h0;
      dog_prev_q <= 1'b0;
      curpos_q   <= 32'h0;
   end
   else
   begin
      state_q    <= state_d;
      remain_q   <= remain_d;
      dog_prev_q <= dog_act;
      if ((state_d == ST_DONE) & (state_q != ST_DONE))
         curpos_q <= homepos_q;                                  // [R10]
      else if (step_rise)
         curpos_q <= dir_down ? curpos_q - 32'h1 : curpos_q + 32'h1;
   end
end

// ----------------------------------------------------------------
// motion command and status outputs
// ----------------------------------------------------------------
always @(posedge CORE_CLK)
begin
   if (!RESETN)
   begin
      CMD_SPEED     <= 32'h0;
      CMD_DIR_DOWN  <= 1'b0;
      CMD_ACC_TIME  <= 16'h0;
      CMD_DEC_TIME  <= 16'h0;
      CMD_DECEL     <= 1'b0;
      HOME_BUSY     <= 1'b0;
      HOME_COMPLETE <= 1'b0;
      HOME_ERROR    <= 1'b0;
   end
   else
   begin
      case (state_q)
         ST_FAST:                 CMD_SPEED <= hspeed_q;         // [R6]
         ST_REAR, ST_TRVL,
         ST_SEEK, ST_SHIFT:       CMD_SPEED <= creep_q;          // [R6]
         default:                 CMD_SPEED <= 32'h0;
      endcase
      CMD_DIR_DOWN  <= dir_down;                                 // [R14]
      CMD_ACC_TIME  <= accdec_q[15:0];                           // [R9]
      CMD_DEC_TIME  <= accdec_q[31:16];                          // [R9]
      // slow-down is asked for from the dog front end onward
      CMD_DECEL     <= moving & (state_q != ST_FAST);            // [R7]
      HOME_BUSY     <= moving;
      HOME_COMPLETE <= (state_q == ST_DONE);                     // [R19]
      HOME_ERROR    <= (state_q == ST_ERR);
   end
end

endmodule
`default_nettype wire

// ---- rtl/dch_defs.vh ----
// Purpose : constants for the dog/count homing sequencer
// Assumes : 32-bit apb data, word-aligned registers
// Notes   : offsets are byte addresses
`ifndef DCH_DEFS_VH
`define DCH_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DCH_OFS_CTRL      8'h00
`define DCH_OFS_MODE      8'h04
`define DCH_OFS_HSPEED    8'h08
`define DCH_OFS_CREEP     8'h0c
`define DCH_OFS_SHIFT     8'h10
`define DCH_OFS_HOMEPOS   8'h14
`define DCH_OFS_POSTDOG   8'h18
`define DCH_OFS_ACCDEC    8'h1c
`define DCH_OFS_STATUS    8'h20
`define DCH_OFS_CURPOS    8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCH_CTRL_ABORT    0
`define DCH_MODE_DIR      4
`define DCH_MODE_POL      5
`define DCH_METHOD_DOG    4'h0
`define DCH_METHOD_COUNT  4'h1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DCH_RST_MODE      32'h0000_0020
`define DCH_RST_SPEED     32'h0000_0000
`define DCH_RST_ACCDEC    32'h0000_0000
`define DCH_RST_WORD      32'h0000_0000

`endif

// ---- dv/dch_homing_assertions.sv ----
// Purpose : temporal checks on the homing sequencer ports
// Assumes : one clock, synchronous active-low reset
// Notes   : attached by bind from the bench top
`timescale 1ns/100ps
`default_nettype none
module dch_chk
(
   // clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RESETN,
   // apb handshake
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PREADY,
   // motion and status
   input wire logic [31:0] CMD_SPEED,
   input wire logic        CMD_DIR_DOWN,
   input wire logic        CMD_DECEL,
   input wire logic        HOME_BUSY,
   input wire logic        HOME_COMPLETE,
   input wire logic        HOME_ERROR
);
   // ------------------------------------------------
   // properties
   // ------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_answer;
      PREADY ##1 !PREADY;
   endsequence
   a_apb_answer: assert property (s_setup |=> s_answer)
      else $error("apb access not answered in one cycle");
   a_busy_alone: assert property (
      HOME_BUSY |-> !HOME_COMPLETE && !HOME_ERROR)
      else $error("busy together with a final status");
   a_decel_busy: assert property (CMD_DECEL |-> HOME_BUSY)
      else $error("deceleration outside homing");
   a_idle_still: assert property (
      !HOME_BUSY |-> CMD_SPEED == 32'h0)
      else $error("speed commanded while idle");
   a_done_rise: assert property (
      $rose(HOME_COMPLETE) |-> $past(HOME_BUSY))
      else $error("complete without a homing run");
   a_dir_hold: assert property (
      HOME_BUSY && $past(HOME_BUSY) |-> $stable(CMD_DIR_DOWN))
      else $error("direction changed during homing");
   a_done_idle: assert property (
      $rose(HOME_COMPLETE) |-> !CMD_DECEL && CMD_SPEED == 32'h0)
      else $error("motion still commanded at completion");
   a_done_stands: assert property (
      HOME_COMPLETE |=> HOME_COMPLETE || HOME_BUSY || HOME_ERROR)
      else $error("complete dropped without a new request");
endmodule
`default_nettype wire

// ---- dv/dch_mach.sv ----
// Purpose : axis model giving feedback steps, dog and index pulses
// Assumes : one step each PER cycles while speed is commanded
// Notes   : travel is counted from the start request, either direction
`timescale 1ns/100ps
`default_nettype none
module dch_mach
#(
   parameter int PER   = 8,
   parameter int DOG_A = 20,
   parameter int DOG_B = 40,
   parameter int IDX   = 16
)
(
   // clock, reset and host
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        arm,
   input  wire logic        pol,
   input  wire logic [31:0] speed,
   // sensors
   output wire logic        dog,
   output logic             index,
   output logic             step
);
   logic [7:0]  div;
   logic [31:0] trav;
   wire         act = trav >= DOG_A && trav < DOG_B;
   // -------------------------------------------------
   // motion
   // -------------------------------------------------
   // slow steps so the block's input latency never overruns a count
   // the dog span is far below the source's minimum hold time; the
   // block never times the dog, so a short span keeps runs brief
   assign dog = pol ? act : !act;
   always @(posedge clk)
   begin
      step  <= 1'b0;
      index <= 1'b0;
      if (!rstn || arm)
      begin
         div  <= 8'h0;
         trav <= 32'h0;
      end
      else if (speed != 32'h0)
      begin
         div <= (div == PER - 1) ? 8'h0 : div + 8'h1;
         if (div == PER - 1)
         begin
            step <= 1'b1;
            trav <= trav + 32'h1;
            index <= ((trav + 1) % IDX) == 0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose : self-checking bench for the homing sequencer
// Assumes : apb answers after one access cycle
// Notes   : dog spans travel 20..40, index every 16 steps
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk, rstn, psel, pen, pwr, hs, ams, pss, two, pol;
   logic        prdy, perr, dir, dcl, busy, cmp, err, dog, idx, stp, e;
   logic [7:0]  paddr, pts;
   logic [15:0] acc, dec;
   logic [31:0] pwd, prd, spd, r;
   int          bad_count, checks, cyc;
   dch_homing u_dch_homing (.CORE_CLK(clk), .RESETN(rstn), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd),
      .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .HOME_START(hs),
      .AUTO_MANUAL_SELECT(ams), .POINT_TABLE_SEL(pts),
      .POS_SPEED_SOURCE_SELECT(pss), .TWO_STATIONS(two), .DOG_IN(dog),
      .INDEX_PULSE(idx), .FB_STEP(stp), .CMD_SPEED(spd),
      .CMD_DIR_DOWN(dir), .CMD_ACC_TIME(acc), .CMD_DEC_TIME(dec),
      .CMD_DECEL(dcl), .HOME_BUSY(busy), .HOME_COMPLETE(cmp),
      .HOME_ERROR(err));
   dch_mach u_dch_mach (.clk(clk), .rstn(rstn), .arm(hs), .pol(pol),
      .speed(spd), .dog(dog), .index(idx), .step(stp));
   // -------------------------------------------------
   // tasks
   // -------------------------------------------------
   task tally_and_finish;
   begin
      $display("mismatches %0d, checks %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
   begin
      checks++;
      if (g !== x)
      begin
         bad_count++;
         $display("mismatch %0t: got %h expected %h", $time, g, x);
      end
   end
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
   begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   end
   endtask
   task kick;
   begin
      @(posedge clk);
      hs <= 1'b1;
      repeat (4) @(posedge clk);
      hs <= 1'b0;
   end
   endtask
   task home(input logic [3:0] m, input logic dr, input logic pl,
             input logic [31:0] sh, input logic [31:0] pd,
             input logic [31:0] t);
   begin
      xfer(1'b1, 8'h04, {26'h0, pl, dr, m});
      xfer(1'b1, 8'h10, sh);
      xfer(1'b1, 8'h18, pd);
      pol <= pl;
      kick;
      while (busy !== 1'b1) @(posedge clk);
      chk(spd, 32'h40);
      chk({31'h0, dir}, {31'h0, dr});
      chk({dec, acc}, 32'h0456_0123);
      while (dcl !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(spd, 32'h8);
      while (cmp !== 1'b1) @(posedge clk);
      chk(u_dch_mach.trav, t);
      xfer(1'b0, 8'h24, 32'h0);
      chk(r, 32'h1234);
   end
   endtask
   // error may already stand from an earlier refusal, so busy is
   // looked at after the run would have shown, not when error rises
   task refuse(input logic [3:0] m, input logic a, input logic s,
               input logic [7:0] p);
   begin
      xfer(1'b1, 8'h04, {28'h0, m});
      ams <= a;
      pss <= s;
      pts <= p;
      kick;
      repeat (3) @(posedge clk);
      chk({31'h0, err}, 32'h1);
      chk({31'h0, busy}, 32'h0);
      ams <= 1'b1;
      pss <= 1'b1;
      pts <= 8'h0;
      repeat (4) @(posedge clk);
   end
   endtask
   // -------------------------------------------------
   // sequence
   // -------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         bad_count++;
         tally_and_finish;
      end
   end
   initial
   begin
      {rstn, psel, pen, pwr, hs, paddr, pwd} = '0;
      {ams, pss, two, pol, pts} = {4'hf, 8'h0};
      {bad_count, checks, cyc} = '0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(1'b0, 8'h04, 32'h0);
      chk(r, 32'h20);
      xfer(1'b0, 8'h28, 32'h0);
      chk({r[31:1], e}, 32'h1);
      xfer(1'b1, 8'h08, 32'h40);
      xfer(1'b1, 8'h0c, 32'h8);
      xfer(1'b1, 8'h14, 32'h1234);
      xfer(1'b1, 8'h1c, 32'h0456_0123);
      home(4'h0, 1'b0, 1'b1, 32'h5, 32'h0, 32'd53);
      refuse(4'h2, 1'b1, 1'b1, 8'h0);
      refuse(4'h0, 1'b0, 1'b1, 8'h0);
      refuse(4'h0, 1'b1, 1'b1, 8'h80);
      refuse(4'h1, 1'b1, 1'b0, 8'h0);
      home(4'h1, 1'b1, 1'b0, 32'h0, 32'h6, 32'd32);
      // abort a run while it seeks the dog, then read the status back
      kick;
      while (busy !== 1'b1) @(posedge clk);
      xfer(1'b0, 8'h20, 32'h0);
      chk(r, 32'h9);
      xfer(1'b1, 8'h00, 32'h1);
      repeat (3) @(posedge clk);
      chk({30'h0, err, busy}, 32'h2);
      xfer(1'b0, 8'h00, 32'h0);
      chk(r, 32'h0);
      xfer(1'b0, 8'h20, 32'h0);
      chk(r, 32'h27);
      tally_and_finish;
   end
endmodule
bind dch_homing dch_chk u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
   .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .CMD_SPEED(CMD_SPEED), .CMD_DIR_DOWN(CMD_DIR_DOWN),
   .CMD_DECEL(CMD_DECEL), .HOME_BUSY(HOME_BUSY),
   .HOME_COMPLETE(HOME_COMPLETE), .HOME_ERROR(HOME_ERROR));
`default_nettype wire
